// >>> core/sas_pkg.sv
package sas_pkg;

  // ----------------------------------------------------------------------
  // Strap levels (one strap pin decoded by the pad into two bits)
  // ----------------------------------------------------------------------
  localparam logic [1:0] SAS_STRAP_LOW  = 2'h0;
  localparam logic [1:0] SAS_STRAP_HIGH = 2'h1;
  localparam logic [1:0] SAS_STRAP_OPEN = 2'h2;

  // ----------------------------------------------------------------------
  // Slave addresses, indexed by high strap then low strap
  // ----------------------------------------------------------------------
  localparam logic [6:0] SAS_ADDR_LL = 7'h3a;
  localparam logic [6:0] SAS_ADDR_LH = 7'h39;
  localparam logic [6:0] SAS_ADDR_LO = 7'h38;
  localparam logic [6:0] SAS_ADDR_HL = 7'h36;
  localparam logic [6:0] SAS_ADDR_HH = 7'h35;
  localparam logic [6:0] SAS_ADDR_HO = 7'h34;
  localparam logic [6:0] SAS_ADDR_OL = 7'h32;
  localparam logic [6:0] SAS_ADDR_OH = 7'h31;
  localparam logic [6:0] SAS_ADDR_OO = 7'h30;

  // ----------------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------------
  localparam logic [3:0] SAS_BITS_PER_WORD = 4'h8;
  localparam logic [3:0] SAS_BIT_CNT_RST   = 4'h0;
  localparam logic [7:0] SAS_BYTE_RST      = 8'h00;
  localparam logic [3:0] SAS_STRAP_RST     = 4'ha;

  // ----------------------------------------------------------------------
  // Protocol states, Gray coded along address, ack, receive data
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SAS_IDLE   = 3'h0,
    SAS_ADDR   = 3'h1,
    SAS_ACK    = 3'h3,
    SAS_RX     = 3'h2,
    SAS_TX     = 3'h6,
    SAS_TX_ACK = 3'h7,
    SAS_IGNORE = 3'h5
  } sas_state_e;

  // ----------------------------------------------------------------------
  // Line conditioner state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } sas_line_s;

  localparam sas_line_s SAS_LINE_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : sas_pkg

// >>> core/sas_line_cond.sv
`timescale 1ns/1ps
`default_nettype none

module sas_line_cond
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Conditioned lines and events
  output logic      sda_level,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  sas_line_s q;
  sas_line_s next_q;

  // ----------------------------------------------------------------------
  // Two-stage synchronisers plus one delay stage for edge finding
  // ----------------------------------------------------------------------
  always_comb begin
    next_q       = q;
    next_q.scl_m = scl_in;
    next_q.scl_s = q.scl_m;
    next_q.scl_d = q.scl_s;
    next_q.sda_m = sda_in;
    next_q.sda_s = q.sda_m;
    next_q.sda_d = q.sda_s;
  end

  // Register the line state; idle-high reset avoids a false START
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= SAS_LINE_RST;
    end else begin
      q <= next_q;
    end
  end

  // Edge and condition decode from synchronised stages only
  assign sda_level = q.sda_s;
  assign scl_rise  = q.scl_s & ~q.scl_d;
  assign scl_fall  = ~q.scl_s & q.scl_d;
  // SDA moving while SCL stays high is a START or STOP
  assign start_det = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
  assign stop_det  = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;

endmodule : sas_line_cond

`default_nettype wire

// >>> core/sas_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none

module sas_i2c_slave
  import sas_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address straps
  input  wire logic [1:0] addr_strap_hi,
  input  wire logic [1:0] addr_strap_lo,
  // Transmit side
  input  wire logic [7:0] tx_data,
  output logic            tx_taken,
  // Receive side
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_first,
  // Bus status
  output logic            bus_busy,
  output logic            addressed,
  output logic            read_dir,
  output logic            repeated_start_cond,
  output logic            stop_seen,
  output logic            stop_illegal
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    sas_state_e st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [3:0] strap_m;
    logic [3:0] strap_s;
    logic [6:0] addr;
    logic       rd;
    logic       first;
    logic       start_hi;
    logic       mack_n;
    logic       sda_out;
    logic       sda_oe;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_first;
    logic       tx_taken;
    logic       busy;
    logic       addressed;
    logic       rep_start;
    logic       stop_seen;
    logic       stop_bad;
  } sas_slave_s;

  localparam sas_slave_s SLAVE_RST = '{
    st:        SAS_IDLE,
    bitn:      SAS_BIT_CNT_RST,
    sh:        SAS_BYTE_RST,
    strap_m:   SAS_STRAP_RST,
    strap_s:   SAS_STRAP_RST,
    addr:      SAS_ADDR_OO,
    rx_data:   SAS_BYTE_RST,
    default:   1'b0
  };

  sas_slave_s q;
  sas_slave_s next_q;

  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // ----------------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------------
  function automatic logic [6:0] strap_addr(input logic [1:0] hi,
                                            input logic [1:0] lo);
    logic [6:0] a;
    a = SAS_ADDR_OO;
    if (hi == SAS_STRAP_LOW) begin
      if (lo == SAS_STRAP_LOW) begin
        a = SAS_ADDR_LL;
      end else if (lo == SAS_STRAP_HIGH) begin
        a = SAS_ADDR_LH;
      end else begin
        a = SAS_ADDR_LO;
      end
    end else if (hi == SAS_STRAP_HIGH) begin
      if (lo == SAS_STRAP_LOW) begin
        a = SAS_ADDR_HL;
      end else if (lo == SAS_STRAP_HIGH) begin
        a = SAS_ADDR_HH;
      end else begin
        a = SAS_ADDR_HO;
      end
    end else begin
      if (lo == SAS_STRAP_LOW) begin
        a = SAS_ADDR_OL;
      end else if (lo == SAS_STRAP_HIGH) begin
        a = SAS_ADDR_OH;
      end else begin
        a = SAS_ADDR_OO;
      end
    end
    return a;
  endfunction : strap_addr

  // ----------------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------------
  sas_line_cond u_line (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_level (sda_level),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  always_comb begin
    next_q           = q;
    // One-cycle strobes
    next_q.rx_valid  = 1'b0;
    next_q.tx_taken  = 1'b0;
    next_q.rep_start = 1'b0;
    next_q.stop_seen = 1'b0;
    next_q.stop_bad  = 1'b0;
    // Data pin only ever sinks; its output value stays low
    next_q.sda_out   = 1'b0;
    // Straps pass two flip-flops before decode
    next_q.strap_m   = {addr_strap_hi, addr_strap_lo};
    next_q.strap_s   = q.strap_m;
    // Address follows the straps only between transfers
    if (q.st == SAS_IDLE) begin
      next_q.addr = strap_addr(q.strap_s[3:2], q.strap_s[1:0]);
    end
    // A clock pulse since the START makes a later STOP legal
    if (scl_fall) begin
      next_q.start_hi = 1'b0;
    end

    if (stop_det && q.start_hi) begin
      // STOP in the same high pulse as START is not honoured
      next_q.stop_bad = 1'b1;
    end else if (stop_det) begin
      // STOP frees the bus from any state and releases the data pin
      next_q.st        = SAS_IDLE;
      next_q.busy      = 1'b0;
      next_q.addressed = 1'b0;
      next_q.sda_oe    = 1'b0;
      next_q.stop_seen = q.busy;
    end else if (start_det) begin
      // START or repeated START opens a new address phase
      next_q.rep_start = q.busy;
      next_q.busy      = 1'b1;
      next_q.addressed = 1'b0;
      next_q.st        = SAS_ADDR;
      next_q.bitn      = SAS_BIT_CNT_RST;
      next_q.sda_oe    = 1'b0;
      next_q.start_hi  = 1'b1;
      next_q.first     = 1'b1;
    end else begin
      case (q.st)
        SAS_ADDR: begin
          // Shift address and direction in on rising clock
          if (scl_rise) begin
            next_q.sh   = {q.sh[6:0], sda_level};
            next_q.bitn = q.bitn + 4'h1;
          end else if (scl_fall && q.bitn == SAS_BITS_PER_WORD) begin
            next_q.bitn = SAS_BIT_CNT_RST;
            if (q.sh[7:1] == q.addr) begin
              // Match: pull low for the acknowledge pulse
              next_q.rd        = q.sh[0];
              next_q.addressed = 1'b1;
              next_q.sda_oe    = 1'b1;
              next_q.st        = SAS_ACK;
            end else begin
              // Another slave: stay off the bus until STOP or START
              next_q.st = SAS_IGNORE;
            end
          end
        end

        SAS_ACK: begin
          // End of acknowledge pulse: release or start sending
          if (scl_fall) begin
            next_q.bitn = SAS_BIT_CNT_RST;
            if (q.rd) begin
              next_q.sh       = tx_data;
              next_q.tx_taken = 1'b1;
              next_q.sda_oe   = ~tx_data[7];
              next_q.st       = SAS_TX;
            end else begin
              next_q.sda_oe = 1'b0;
              next_q.st     = SAS_RX;
            end
          end
        end

        SAS_RX: begin
          // Command or data byte from the master
          if (scl_rise) begin
            next_q.sh   = {q.sh[6:0], sda_level};
            next_q.bitn = q.bitn + 4'h1;
          end else if (scl_fall && q.bitn == SAS_BITS_PER_WORD) begin
            next_q.bitn     = SAS_BIT_CNT_RST;
            next_q.rx_data  = q.sh;
            next_q.rx_valid = 1'b1;
            next_q.rx_first = q.first;
            next_q.first    = 1'b0;
            next_q.sda_oe   = 1'b1;
            next_q.st       = SAS_ACK;
          end
        end

        SAS_TX: begin
          // Byte out MSB first, next bit placed after each falling clock
          if (scl_rise) begin
            next_q.bitn = q.bitn + 4'h1;
          end else if (scl_fall) begin
            if (q.bitn == SAS_BITS_PER_WORD) begin
              // Release so the master can acknowledge
              next_q.bitn   = SAS_BIT_CNT_RST;
              next_q.sda_oe = 1'b0;
              next_q.st     = SAS_TX_ACK;
            end else begin
              next_q.sda_oe = ~q.sh[6];
              next_q.sh     = {q.sh[6:0], 1'b0};
            end
          end
        end

        SAS_TX_ACK: begin
          // Master acknowledge asks for another byte, no-ack ends it
          if (scl_rise) begin
            next_q.mack_n = sda_level;
          end else if (scl_fall) begin
            next_q.bitn = SAS_BIT_CNT_RST;
            if (q.mack_n) begin
              next_q.st = SAS_IGNORE;
            end else begin
              next_q.sh       = tx_data;
              next_q.tx_taken = 1'b1;
              next_q.sda_oe   = ~tx_data[7];
              next_q.st       = SAS_TX;
            end
          end
        end

        SAS_IGNORE: begin
          // Bus stays busy, pin released, wait for STOP or START
          next_q.sda_oe = 1'b0;
        end

        default: begin
          next_q.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= SLAVE_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state record
  // ----------------------------------------------------------------------
  assign sda_out             = q.sda_out;
  assign sda_oe              = q.sda_oe;
  assign tx_taken            = q.tx_taken;
  assign rx_data             = q.rx_data;
  assign rx_valid            = q.rx_valid;
  assign rx_first            = q.rx_first;
  assign bus_busy            = q.busy;
  assign addressed           = q.addressed;
  assign read_dir            = q.rd;
  assign repeated_start_cond = q.rep_start;
  assign stop_seen           = q.stop_seen;
  assign stop_illegal        = q.stop_bad;

endmodule : sas_i2c_slave

`default_nettype wire

// >>> testbench/sas_props.sv
`timescale 1ns/1ps
`default_nettype none

module sas_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus pins and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic tx_taken,
  input wire logic rx_valid,
  input wire logic bus_busy,
  input wire logic addressed,
  input wire logic read_dir,
  input wire logic repeated_start_cond,
  input wire logic stop_seen,
  input wire logic stop_illegal
);
  // ----
  // Bus relations
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_drive_low:
    assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  chk_idle_release:
    assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
      else $error("sda held low while idle");
  chk_oe_scl_low:
    assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
      else $error("sda moved while scl high");
  chk_bit_hold:
    assert property ($rose(sda_oe) |-> sda_oe[*8])
      else $error("driven bit shorter than a pulse");
  chk_ack_byte:
    assert property (rx_valid |-> ##[0:1] sda_oe) else $error("no ack");
  chk_rx_addressed:
    assert property (rx_valid |-> addressed && !read_dir)
      else $error("byte taken unaddressed");
  chk_tx_read:
    assert property (tx_taken |-> addressed && read_dir)
      else $error("byte sent outside read");
  chk_start_busy:
    assert property ($fell(sda_in) && scl_in && !bus_busy |->
                     ##[2:6] bus_busy) else $error("start missed");
  chk_stop_free:
    assert property (stop_seen |-> ##[0:1] !bus_busy)
      else $error("stop left bus busy");
  chk_rs_busy:
    assert property (repeated_start_cond |-> bus_busy ##1 bus_busy)
      else $error("repeated start freed bus");
  chk_illegal_busy:
    assert property (stop_illegal |-> !stop_seen ##1 bus_busy)
      else $error("illegal stop honoured");
endmodule : sas_props

bind sas_i2c_slave sas_props u_sas_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .tx_taken(tx_taken),
  .rx_valid(rx_valid), .bus_busy(bus_busy), .addressed(addressed),
  .read_dir(read_dir), .repeated_start_cond(repeated_start_cond),
  .stop_seen(stop_seen), .stop_illegal(stop_illegal));

`default_nettype wire

// >>> testbench/sas_master.sv
`timescale 1ns/1ps
`default_nettype none

module sas_master (
  // Clock
  input  wire logic ref_clk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  // Both lines released while idle
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Wait whole system cycles
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w
  // START or repeated START, data falls with clock high
  task automatic start();
    w(3);
    sda_rel = 1'b1;
    w(3);
    scl = 1'b1;
    w(4);
    sda_rel = 1'b0;
    w(4);
    scl = 1'b0;
  endtask : start
  // STOP, data rises with clock high
  task automatic stop();
    w(3);
    sda_rel = 1'b0;
    w(3);
    scl = 1'b1;
    w(4);
    sda_rel = 1'b1;
    w(4);
  endtask : stop
  // START and STOP in one clock high
  task automatic start_stop();
    w(4);
    sda_rel = 1'b0;
    w(4);
    sda_rel = 1'b1;
    w(4);
  endtask : start_stop
  // One bit per pulse, 8 cycles (320 ns); data moves only while low
  task automatic xfer(input logic b, output logic r);
    w(2);
    sda_rel = b;
    w(2);
    scl = 1'b1;
    w(4);
    r = sda;
    scl = 1'b0;
  endtask : xfer
  // Byte out MSB first, then the ack pulse
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask : wr
  // Byte in, then master ack or no-ack
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(~mack, r);
  endtask : rd
endmodule : sas_master

`default_nettype wire

// >>> testbench/sas_i2c_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module sas_i2c_slave_bench import sas_pkg::*;;
  logic       ref_clk, rst_n, scl, sda_rel, sda_out, sda_oe, ack, r;
  logic       tx_taken, rx_valid, rx_first, bus_busy, addressed, read_dir;
  logic       repeated_start_cond, stop_seen, stop_illegal;
  logic [1:0] addr_strap_hi, addr_strap_lo;
  logic [7:0] tx_data, rx_data, rnd, got;
  logic [8:0] note;
  logic [8:0] exp_q [$];
  logic [6:0] addr_tab [9] = '{SAS_ADDR_LL, SAS_ADDR_LH, SAS_ADDR_LO,
    SAS_ADDR_HL, SAS_ADDR_HH, SAS_ADDR_HO, SAS_ADDR_OL, SAS_ADDR_OH,
    SAS_ADDR_OO};
  int         errors, total_checks;
  int         n_tx, n_rs, n_stop, n_bad;
  wire logic  sda = sda_rel & ~sda_oe; // Open drain with pull-up

  sas_i2c_slave u_sas_i2c_slave (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_hi(addr_strap_hi), .addr_strap_lo(addr_strap_lo),
    .tx_data(tx_data), .tx_taken(tx_taken), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_first(rx_first), .bus_busy(bus_busy),
    .addressed(addressed), .read_dir(read_dir),
    .repeated_start_cond(repeated_start_cond), .stop_seen(stop_seen),
    .stop_illegal(stop_illegal));
  sas_master u_sas_master (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_rel(sda_rel));

  // Pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // System clock, 40 ns
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Received bytes against the oldest note, mid-cycle; pulses counted
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      `CHK({rx_first, rx_data}, note)
    end
    if (tx_taken === 1'b1) n_tx++;
    if (repeated_start_cond === 1'b1) n_rs++;
    if (stop_seen === 1'b1) n_stop++;
    if (stop_illegal === 1'b1) n_bad++;
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    addr_strap_hi = 2'h0;
    addr_strap_lo = 2'h0;
    tx_data = 8'h00;
    rnd = 8'h01;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    // Each strap pair: foreign address ignored, own one takes cmd and data
    for (int i = 0; i < 9; i++) begin
      addr_strap_hi = 2'(i / 3);
      addr_strap_lo = 2'(i % 3);
      u_sas_master.w(12);
      u_sas_master.start();
      u_sas_master.wr({addr_tab[i] ^ 7'h40, 1'b0}, ack);
      `CHK(ack, 1'b0)
      `CHK(addressed, 1'b0)
      u_sas_master.stop();
      u_sas_master.start();
      u_sas_master.wr({addr_tab[i], 1'b0}, ack);
      `CHK(ack, 1'b1)
      for (int k = 0; k < 2; k++) begin
        rnd = lfsr(rnd);
        exp_q.push_back({k == 0, rnd});
        u_sas_master.wr(rnd, ack);
        `CHK(ack, 1'b1)
      end
      u_sas_master.stop();
    end
    // Command write turned round by repeated START, two bytes read back
    rnd = lfsr(rnd);
    exp_q.push_back({1'b1, rnd});
    u_sas_master.start();
    u_sas_master.wr({SAS_ADDR_OO, 1'b0}, ack);
    u_sas_master.wr(rnd, ack);
    rnd = lfsr(rnd);
    tx_data = rnd;
    u_sas_master.start();
    `CHK(bus_busy, 1'b1)
    u_sas_master.wr({SAS_ADDR_OO, 1'b1}, ack);
    `CHK(read_dir, 1'b1)
    u_sas_master.rd(1'b1, got);
    `CHK(got, rnd)
    rnd = lfsr(rnd);
    tx_data = rnd;
    u_sas_master.rd(1'b0, got);
    `CHK(got, rnd)
    u_sas_master.stop();
    // STOP in mid-byte is honoured
    u_sas_master.start();
    u_sas_master.wr({SAS_ADDR_OO, 1'b0}, ack);
    for (int k = 0; k < 3; k++) u_sas_master.xfer(1'b1, r);
    u_sas_master.stop();
    u_sas_master.w(4);
    `CHK(bus_busy, 1'b0)
    // STOP in the START's clock high is ignored until a pulse passes
    u_sas_master.start_stop();
    `CHK(bus_busy, 1'b1)
    u_sas_master.xfer(1'b1, r);
    u_sas_master.stop();
    u_sas_master.w(4);
    `CHK(bus_busy, 1'b0)
    `CHK(exp_q.size(), 0)
    `CHK(n_tx, 2)
    `CHK(n_rs, 1)
    `CHK(n_stop, 21)
    `CHK(n_bad, 1)
    finish_test();
  end
endmodule : sas_i2c_slave_bench

`default_nettype wire
